// ===== bus_timing_power_down_control.sv
`timescale 1ns/10ps
//Contract
// - Busy-mode bit zero: I/O write to F8..FF raises processor busy early.
// - Busy-mode bit 15 is ignored when a 32-bit core is attached.
// - Bit 14 rising from zero to one starts processor power-down; bus keeps running.
// - Processor power-down plus halt: processor inputs passive, their pullups off.
// - In processor power-down, output 5 set and processor outputs released.
// - Unmasked interrupt, DMA request or NMI clears output 5.
// - Power good high: drive processor outputs, reset processor; readable in status bit 1.
// - Full power-down plus halt: release most outputs, ignore most inputs.
// - Full power-down stops internals except power control and refresh; CBR if enabled.
// - Entering full power-down sets output 7.
// - Full power-down routes the external 64 KHz refresh input to refresh output.
// - Power-management interrupt in full power-down clears output 7, starting power-up.
// - Power-up holds processor and system reset until power good is high.
// - Full power-down bit stays one until software writes zero.
// - Written value of bit 12 is ignored.
// - Bus mode selects bus source or processor clock, divided by two or not.
// - Bus clock is always halved; mode 00 gives 4 MHz from 16 MHz.
// - Modes 10 and 11 skip synchronisation delays; 00 and 01 apply them.
// - Request delay codes: one clock, half clock, none, reserved.
// - Acknowledge delay codes: none, minus half, minus one, plus half clock.
// - Wide I/O and memory wait bits give one or two wait states.
// - Narrow I/O and memory wait fields give two to five wait states.
// - Any write to port 0F0 deasserts the coprocessor busy signal; here a busy pin rising in the same cycle sets it instead.
module bus_timing_power_down_control (
	input wire logic clk_i,
	input wire logic arst_n_i,
	input wire logic [15:0] io_addr_i,
	input wire logic [15:0] io_wdata_i,
	input wire logic io_wr_i,
	input wire logic io_rd_i,
	input wire logic halt_i,
	input wire logic irq_i,
	input wire logic dma_req_i,
	input wire logic nmi_i,
	input wire logic pmc_irq_i,
	input wire logic processor_power_good_i,
	input wire logic coproc_busy_i,
	input wire logic wide_core_i,
	input wire logic powerdown_refresh_in_i,
	input wire logic bus_source_clock_i,
	input wire logic processor_clock_i,
	input wire logic refresh_req_i,
	input wire logic cbr_refresh_en_i,
	output logic [15:0] io_rdata_o,
	output logic io_rvalid_o,
	output logic processor_busy_out_o,
	output logic [7:0] power_mgmt_control_o,
	output logic processor_oe_n_o,
	output logic periph_oe_n_o,
	output logic processor_input_mask_o,
	output logic processor_pullup_en_o,
	output logic all_input_mask_o,
	output logic internal_stop_o,
	output logic cbr_refresh_o,
	output logic refresh_o,
	output logic processor_reset_out_o,
	output logic system_reset_hold_o,
	output logic expansion_bus_clock_o,
	output bus_power_pkg::bus_timing_t bus_timing_o
);

	bus_power_pkg::pins_t pins_raw;
	bus_power_pkg::pins_t pins;
	bus_power_pkg::bus_timing_t next_bus_timing;
	bus_power_pkg::pm_state_t state;
	bus_power_pkg::pm_state_t next_state;
	logic [15:0] ctrl;
	logic [15:0] next_ctrl;
	logic [15:0] next_rdata;
	logic next_rvalid;
	logic busy_pin_prev;
	logic next_busy_pin_prev;
	logic next_busy;
	logic wide_core;
	logic next_wide_core;
	logic [1:0] strap_count;
	logic [1:0] next_strap_count;
	logic [3:0] reset_count;
	logic [3:0] next_reset_count;
	logic proc_masked;
	logic wr_ctrl;
	logic wr_busy_clear;
	logic wr_coproc;
	logic halt_seen;
	logic wake_proc;
	logic next_proc_oe_n;
	logic next_periph_oe_n;
	logic next_proc_mask;
	logic next_all_mask;
	logic next_stop;
	logic next_cbr;
	logic next_refresh;
	logic next_proc_reset;
	logic next_sys_reset;
	logic [7:0] next_pmc;

	// Every pin from the processor and the power logic is synchronised once here.
	always_comb begin
		pins_raw.halt = halt_i;
		pins_raw.irq = irq_i;
		pins_raw.dma_req = dma_req_i;
		pins_raw.nmi = nmi_i;
		pins_raw.pmc_irq = pmc_irq_i;
		pins_raw.power_good = processor_power_good_i;
		pins_raw.coproc_busy = coproc_busy_i;
		pins_raw.wide_core = wide_core_i;
		pins_raw.powerdown_refresh_in = powerdown_refresh_in_i;
		pins_raw.bus_src_clk = bus_source_clock_i;
		pins_raw.proc_clk = processor_clock_i;
	end

	pin_sync #(
		.WIDTH($bits(bus_power_pkg::pins_t))
	) u_pin_sync (
		.clk_i(clk_i),
		.arst_n_i(arst_n_i),
		.d_i(pins_raw),
		.q_o(pins)
	);

	bus_clock_divider u_bus_clock_divider (
		.clk_i(clk_i),
		.arst_n_i(arst_n_i),
		.bus_src_i(pins.bus_src_clk),
		.proc_src_i(pins.proc_clk),
		.mode_i(ctrl[bus_power_pkg::MODE_LO +: 2]),
		.clk_o(expansion_bus_clock_o)
	);

	// Host accesses are decoded here; while the processor side is masked the host is
	// powered off, so its strobes are not trusted and are dropped.
	always_comb begin
		proc_masked = processor_input_mask_o;
		wr_ctrl = io_wr_i && !proc_masked && io_addr_i == bus_power_pkg::CTRL_PORT;
		wr_busy_clear = io_wr_i && !proc_masked && io_addr_i == bus_power_pkg::BUSY_CLEAR_PORT;
		wr_coproc = io_wr_i && !proc_masked && io_addr_i >= bus_power_pkg::COPROC_PORT_LO
			&& io_addr_i <= bus_power_pkg::COPROC_PORT_HI;
		halt_seen = pins.halt && !proc_masked;
		wake_proc = pins.irq || pins.dma_req || pins.nmi;
	end

	// Control register: bit 12 never stores, and the full power-down bit only
	// changes when software writes it, never on wake-up.
	always_comb begin
		next_ctrl = ctrl;
		if (wr_ctrl) begin
			next_ctrl = io_wdata_i & bus_power_pkg::CTRL_WRITABLE;
		end
	end

	// Read data answer one cycle after the strobe; unmapped ports read as zero.
	always_comb begin
		next_rvalid = io_rd_i && !proc_masked;
		next_rdata = 16'h0000;
		if (io_addr_i == bus_power_pkg::CTRL_PORT) begin
			next_rdata = ctrl;
		end else if (io_addr_i == bus_power_pkg::STATUS_PORT) begin
			next_rdata[bus_power_pkg::STATUS_PG_BIT] = pins.power_good;
		end
		if (!next_rvalid) begin
			next_rdata = 16'h0000;
		end
	end

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			ctrl <= bus_power_pkg::CTRL_RESET;
			io_rdata_o <= 16'h0000;
			io_rvalid_o <= 1'b0;
		end else begin
			ctrl <= next_ctrl;
			io_rdata_o <= next_rdata;
			io_rvalid_o <= next_rvalid;
		end
	end

	// The core-width strap is taken once, a few cycles after reset release, so the
	// synchroniser has settled; an async reset cannot load a pin value directly.
	always_comb begin
		next_strap_count = strap_count;
		next_wide_core = wide_core;
		if (strap_count != bus_power_pkg::STRAP_SETTLE_CYCLES) begin
			next_strap_count = strap_count + 2'h1;
			next_wide_core = pins.wide_core;
		end
	end

	// Busy latch: a rising coprocessor busy, or the early raise on a coprocessor port
	// write, sets it; a write to 0F0 clears it. A set in the clearing cycle wins.
	always_comb begin
		next_busy_pin_prev = pins.coproc_busy && !proc_masked;
		next_busy = processor_busy_out_o;
		if (wr_busy_clear) begin
			next_busy = 1'b0;
		end
		if (pins.coproc_busy && !busy_pin_prev && !proc_masked) begin
			next_busy = 1'b1;
		end
		if (wr_coproc && !ctrl[bus_power_pkg::BIT_BUSY_MODE] && !wide_core) begin
			next_busy = 1'b1;
		end
	end

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			strap_count <= 2'h0;
			wide_core <= 1'b0;
			busy_pin_prev <= 1'b0;
			processor_busy_out_o <= 1'b0;
		end else begin
			strap_count <= next_strap_count;
			wide_core <= next_wide_core;
			busy_pin_prev <= next_busy_pin_prev;
			processor_busy_out_o <= next_busy;
		end
	end

	// Power-down sequencer. Full power-down takes priority over processor power-down
	// when both are pending at the halt.
	always_comb begin
		next_state = state;
		next_reset_count = reset_count;
		unique case (state)
			bus_power_pkg::PM_RUN, bus_power_pkg::PM_PROC_ARMED: begin
				if (state == bus_power_pkg::PM_RUN && wr_ctrl
					&& !ctrl[bus_power_pkg::BIT_PROC_PD] && io_wdata_i[bus_power_pkg::BIT_PROC_PD]) begin
					next_state = bus_power_pkg::PM_PROC_ARMED;
				end
				if (halt_seen && ctrl[bus_power_pkg::BIT_FULL_PD]) begin
					next_state = bus_power_pkg::PM_FULL_OFF;
				end else if (halt_seen && state == bus_power_pkg::PM_PROC_ARMED) begin
					next_state = bus_power_pkg::PM_PROC_OFF;
				end
			end
			bus_power_pkg::PM_PROC_OFF: begin
				if (wake_proc) begin
					next_state = bus_power_pkg::PM_PROC_WAKE;
				end
			end
			bus_power_pkg::PM_PROC_WAKE, bus_power_pkg::PM_FULL_WAKE: begin
				if (pins.power_good) begin
					next_state = bus_power_pkg::PM_PROC_RESET;
					next_reset_count = bus_power_pkg::PROC_RESET_CYCLES;
				end
			end
			bus_power_pkg::PM_PROC_RESET: begin
				next_reset_count = reset_count - 4'h1;
				if (reset_count == 4'h1) begin
					next_state = bus_power_pkg::PM_RUN;
				end
			end
			bus_power_pkg::PM_FULL_OFF: begin
				if (pins.pmc_irq) begin
					next_state = bus_power_pkg::PM_FULL_WAKE;
				end
			end
		endcase
	end

	// Outputs are decoded from the next state so they change with the state flop.
	always_comb begin
		next_pmc = 8'h00;
		next_pmc[bus_power_pkg::PMC_PROC_BIT] = next_state == bus_power_pkg::PM_PROC_OFF;
		next_pmc[bus_power_pkg::PMC_FULL_BIT] = next_state == bus_power_pkg::PM_FULL_OFF;
		next_all_mask = next_state == bus_power_pkg::PM_FULL_OFF
			|| next_state == bus_power_pkg::PM_FULL_WAKE;
		next_proc_mask = next_all_mask || next_state == bus_power_pkg::PM_PROC_OFF
			|| next_state == bus_power_pkg::PM_PROC_WAKE;
		next_proc_oe_n = next_proc_mask;
		next_periph_oe_n = next_all_mask;
		next_stop = next_state == bus_power_pkg::PM_FULL_OFF;
		next_cbr = next_stop && cbr_refresh_en_i;
		next_refresh = next_stop ? pins.powerdown_refresh_in : refresh_req_i;
		next_proc_reset = next_state == bus_power_pkg::PM_PROC_WAKE
			|| next_state == bus_power_pkg::PM_FULL_WAKE
			|| next_state == bus_power_pkg::PM_PROC_RESET;
		next_sys_reset = next_state == bus_power_pkg::PM_FULL_WAKE;
	end

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			state <= bus_power_pkg::PM_RUN;
			reset_count <= 4'h0;
			power_mgmt_control_o <= 8'h00;
			processor_oe_n_o <= 1'b0;
			periph_oe_n_o <= 1'b0;
			processor_input_mask_o <= 1'b0;
			processor_pullup_en_o <= 1'b1;
			all_input_mask_o <= 1'b0;
			internal_stop_o <= 1'b0;
			cbr_refresh_o <= 1'b0;
			refresh_o <= 1'b0;
			processor_reset_out_o <= 1'b0;
			system_reset_hold_o <= 1'b0;
		end else begin
			state <= next_state;
			reset_count <= next_reset_count;
			power_mgmt_control_o <= next_pmc;
			processor_oe_n_o <= next_proc_oe_n;
			periph_oe_n_o <= next_periph_oe_n;
			processor_input_mask_o <= next_proc_mask;
			processor_pullup_en_o <= !next_proc_mask;
			all_input_mask_o <= next_all_mask;
			internal_stop_o <= next_stop;
			cbr_refresh_o <= next_cbr;
			refresh_o <= next_refresh;
			processor_reset_out_o <= next_proc_reset;
			system_reset_hold_o <= next_sys_reset;
		end
	end

	// Bus timing decode. Synchronous modes skip both delays; reserved request code 11
	// falls back to the default one-clock delay as the safe choice.
	always_comb begin
		next_bus_timing.sync_skip = ctrl[bus_power_pkg::MODE_LO + 1];
		unique case (ctrl[bus_power_pkg::REQ_LO +: 2])
			2'h0: next_bus_timing.req_delay_half = 2'h2;
			2'h1: next_bus_timing.req_delay_half = 2'h1;
			2'h2: next_bus_timing.req_delay_half = 2'h0;
			2'h3: next_bus_timing.req_delay_half = 2'h2;
		endcase
		unique case (ctrl[bus_power_pkg::ACK_LO +: 2])
			2'h0: next_bus_timing.ack_adjust_half = 3'h0;
			2'h1: next_bus_timing.ack_adjust_half = 3'h7;
			2'h2: next_bus_timing.ack_adjust_half = 3'h6;
			2'h3: next_bus_timing.ack_adjust_half = 3'h1;
		endcase
		if (next_bus_timing.sync_skip) begin
			next_bus_timing.req_delay_half = 2'h0;
			next_bus_timing.ack_adjust_half = 3'h0;
		end
		next_bus_timing.wait_io_wide = {2'h0, ctrl[bus_power_pkg::BIT_IO_WIDE]} + 3'h1;
		next_bus_timing.wait_mem_wide = {2'h0, ctrl[bus_power_pkg::BIT_MEM_WIDE]} + 3'h1;
		next_bus_timing.wait_io_narrow = {1'b0, ctrl[bus_power_pkg::IO_NARROW_LO +: 2]} + 3'h2;
		next_bus_timing.wait_mem_narrow = {1'b0, ctrl[bus_power_pkg::MEM_NARROW_LO +: 2]} + 3'h2;
	end

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			bus_timing_o <= '0;
		end else begin
			bus_timing_o <= next_bus_timing;
		end
	end

endmodule

// ===== bus_power_pkg.sv
package bus_power_pkg;

	// Port addresses on the host I/O space.
	localparam logic [15:0] CTRL_PORT = 16'h1872;
	localparam logic [15:0] BUSY_CLEAR_PORT = 16'h00F0;
	localparam logic [15:0] STATUS_PORT = 16'h9072;
	localparam logic [15:0] COPROC_PORT_LO = 16'h00F8;
	localparam logic [15:0] COPROC_PORT_HI = 16'h00FF;

	// Field positions of the control register.
	localparam int BIT_BUSY_MODE = 15;
	localparam int BIT_PROC_PD = 14;
	localparam int BIT_FULL_PD = 13;
	localparam int MODE_LO = 10;
	localparam int REQ_LO = 8;
	localparam int ACK_LO = 6;
	localparam int BIT_IO_WIDE = 5;
	localparam int BIT_MEM_WIDE = 4;
	localparam int IO_NARROW_LO = 2;
	localparam int MEM_NARROW_LO = 0;

	// Value after reset, and the bits that keep a written value (bit 12 does not).
	localparam logic [15:0] CTRL_RESET = 16'h00CA;
	localparam logic [15:0] CTRL_WRITABLE = 16'hEFFF;

	// Status and power-management output bit positions.
	localparam int STATUS_PG_BIT = 1;
	localparam int PMC_PROC_BIT = 5;
	localparam int PMC_FULL_BIT = 7;

	// Cycle counts.
	// The strap needs three edges after release: two through the synchroniser, one to load.
	localparam logic [1:0] STRAP_SETTLE_CYCLES = 2'h3;
	localparam logic [3:0] PROC_RESET_CYCLES = 4'h8;

	// Bus timing handed to the expansion bus sequencer, delays in half bus clocks, waits in wait states.
	typedef struct packed {
		logic sync_skip;
		logic [1:0] req_delay_half;
		logic [2:0] ack_adjust_half;
		logic [2:0] wait_io_wide;
		logic [2:0] wait_mem_wide;
		logic [2:0] wait_io_narrow;
		logic [2:0] wait_mem_narrow;
	} bus_timing_t;

	// Pins from outside the clock domain, carried through one synchroniser.
	typedef struct packed {
		logic halt;
		logic irq;
		logic dma_req;
		logic nmi;
		logic pmc_irq;
		logic power_good;
		logic coproc_busy;
		logic wide_core;
		logic powerdown_refresh_in;
		logic bus_src_clk;
		logic proc_clk;
	} pins_t;

	typedef enum {
		PM_RUN,
		PM_PROC_ARMED,
		PM_PROC_OFF,
		PM_PROC_WAKE,
		PM_PROC_RESET,
		PM_FULL_OFF,
		PM_FULL_WAKE
	} pm_state_t;

endpackage

// ===== pin_sync.sv
`timescale 1ns/10ps
module pin_sync #(
	parameter int WIDTH = 1
) (
	input wire logic clk_i,
	input wire logic arst_n_i,
	input wire logic [WIDTH-1:0] d_i,
	output logic [WIDTH-1:0] q_o
);

	logic [WIDTH-1:0] stage;
	logic [WIDTH-1:0] next_stage;
	logic [WIDTH-1:0] next_q;

	// The first stage feeds only the second, so metastability never reaches logic.
	always_comb begin
		next_stage = d_i;
		next_q = stage;
	end

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			stage <= '0;
			q_o <= '0;
		end else begin
			stage <= next_stage;
			q_o <= next_q;
		end
	end

endmodule

// ===== bus_clock_divider.sv
`timescale 1ns/10ps
module bus_clock_divider (
	input wire logic clk_i,
	input wire logic arst_n_i,
	input wire logic bus_src_i,
	input wire logic proc_src_i,
	input wire logic [1:0] mode_i,
	output logic clk_o
);

	logic prev;
	logic half;
	logic next_prev;
	logic next_half;
	logic next_clk;
	logic src;
	logic rise;

	// Mode bit 1 picks the processor clock; mode bit 0 drops the extra halving.
	// The output always halves the chosen source, and halves again in modes 00 and 10.
	always_comb begin
		src = mode_i[1] ? proc_src_i : bus_src_i;
		rise = src & ~prev;
		next_prev = src;
		next_half = half;
		next_clk = clk_o;
		if (rise) begin
			if (mode_i[0]) begin
				next_clk = ~clk_o;
			end else begin
				next_half = ~half;
				if (half) begin
					next_clk = ~clk_o;
				end
			end
		end
	end

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			prev <= 1'b0;
			half <= 1'b0;
			clk_o <= 1'b0;
		end else begin
			prev <= next_prev;
			half <= next_half;
			clk_o <= next_clk;
		end
	end

endmodule

// ===== bus_timing_power_down_control_properties.sv
`timescale 1ns/10ps
module bus_timing_power_down_control_properties (
	input wire logic clk_i,
	input wire logic arst_n_i,
	input wire logic [15:0] io_addr_i,
	input wire logic [15:0] io_wdata_i,
	input wire logic io_wr_i,
	input wire logic io_rd_i,
	input wire logic wide_core_i,
	input wire logic [15:0] io_rdata_o,
	input wire logic io_rvalid_o,
	input wire logic processor_busy_out_o,
	input wire logic [7:0] power_mgmt_control_o,
	input wire logic processor_oe_n_o,
	input wire logic periph_oe_n_o,
	input wire logic processor_input_mask_o,
	input wire logic processor_pullup_en_o,
	input wire logic all_input_mask_o,
	input wire logic internal_stop_o,
	input wire logic processor_reset_out_o,
	input wire logic system_reset_hold_o,
	input wire bus_power_pkg::bus_timing_t bus_timing_o
);
	logic [15:0] ctrl_m;
	logic [15:0] next_ctrl_m;
	logic take;
	logic coproc_wr;
	// Host cycles count only while the processor side is not masked.
	assign take = !processor_input_mask_o;
	assign coproc_wr = io_wr_i && take && io_addr_i >= 16'h00F8 && io_addr_i <= 16'h00FF;
	// Shadow of the control register, so the decode can be judged without the body.
	always_comb begin
		next_ctrl_m = ctrl_m;
		if (io_wr_i && take && io_addr_i == 16'h1872) begin
			next_ctrl_m = io_wdata_i & 16'hEFFF;
		end
	end
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			ctrl_m <= 16'h00CA;
		end else begin
			ctrl_m <= next_ctrl_m;
		end
	end
	default clocking @(posedge clk_i); endclocking
	default disable iff (!arst_n_i);
	a_busy_early: assert property (
		coproc_wr && !ctrl_m[15] && !wide_core_i |=> processor_busy_out_o)
		else $error("early busy missing after coprocessor write");
	a_busy_quiet: assert property (
		coproc_wr && (ctrl_m[15] || wide_core_i) && !processor_busy_out_o |=> !processor_busy_out_o)
		else $error("busy raised although early busy is off");
	a_busy_clear: assert property (
		io_wr_i && take && io_addr_i == 16'h00F0 |=> !processor_busy_out_o)
		else $error("busy kept after clear strobe");
	a_ctrl_read: assert property (
		io_rd_i && take && io_addr_i == 16'h1872 |=> io_rvalid_o && io_rdata_o == ctrl_m)
		else $error("control read returned wrong value");
	a_wait_decode: assert property (
		$past(arst_n_i) && $stable(ctrl_m) |->
		bus_timing_o.wait_io_narrow == {1'b0, ctrl_m[3:2]} + 3'h2 &&
		bus_timing_o.wait_mem_narrow == {1'b0, ctrl_m[1:0]} + 3'h2 &&
		bus_timing_o.wait_io_wide == (ctrl_m[5] ? 3'h2 : 3'h1) &&
		bus_timing_o.wait_mem_wide == (ctrl_m[4] ? 3'h2 : 3'h1))
		else $error("wait states do not match control register");
	a_sync_skip: assert property (
		$past(arst_n_i) && $stable(ctrl_m) && ctrl_m[11] |-> bus_timing_o.sync_skip &&
		bus_timing_o.req_delay_half == 2'h0 && bus_timing_o.ack_adjust_half == 3'h0)
		else $error("synchronous mode still applies delays");
	a_req_async: assert property (
		$past(arst_n_i) && $stable(ctrl_m) && !ctrl_m[11] |-> !bus_timing_o.sync_skip &&
		bus_timing_o.req_delay_half == (ctrl_m[9:8] == 2'h1 ? 2'h1 : ctrl_m[9:8] == 2'h2 ? 2'h0 : 2'h2))
		else $error("request delay does not match its code");
	a_proc_off: assert property (
		power_mgmt_control_o[5] |-> processor_oe_n_o && processor_input_mask_o && !processor_pullup_en_o)
		else $error("processor side not released while its power is off");
	a_full_off: assert property (
		power_mgmt_control_o[7] |-> periph_oe_n_o && all_input_mask_o && internal_stop_o)
		else $error("full power-down outputs inconsistent");
	a_wake_reset: assert property (
		$fell(processor_oe_n_o) |-> processor_reset_out_o ##[1:12] !processor_reset_out_o)
		else $error("processor reset not pulsed on power good");
	a_hold_reset: assert property (
		system_reset_hold_o |-> processor_reset_out_o)
		else $error("system reset held without processor reset");
endmodule

bind bus_timing_power_down_control bus_timing_power_down_control_properties i_props (
	.clk_i(clk_i),
	.arst_n_i(arst_n_i),
	.io_addr_i(io_addr_i),
	.io_wdata_i(io_wdata_i),
	.io_wr_i(io_wr_i),
	.io_rd_i(io_rd_i),
	.wide_core_i(wide_core_i),
	.io_rdata_o(io_rdata_o),
	.io_rvalid_o(io_rvalid_o),
	.processor_busy_out_o(processor_busy_out_o),
	.power_mgmt_control_o(power_mgmt_control_o),
	.processor_oe_n_o(processor_oe_n_o),
	.periph_oe_n_o(periph_oe_n_o),
	.processor_input_mask_o(processor_input_mask_o),
	.processor_pullup_en_o(processor_pullup_en_o),
	.all_input_mask_o(all_input_mask_o),
	.internal_stop_o(internal_stop_o),
	.processor_reset_out_o(processor_reset_out_o),
	.system_reset_hold_o(system_reset_hold_o),
	.bus_timing_o(bus_timing_o)
);

// ===== cpu_rail_model.sv
`timescale 1ns/10ps
module cpu_rail_model #(
	parameter int RAMP = 20
) (
	input wire logic clk_i,
	input wire logic off_i,
	input wire logic halt_req_i,
	output logic power_good_o,
	output logic halt_o
);
	int ramp_cnt = RAMP;
	// Power good sags as soon as the rail is cut and returns only after a ramp.
	always @(posedge clk_i) begin
		if (off_i) begin
			ramp_cnt <= 0;
		end else if (ramp_cnt < RAMP) begin
			ramp_cnt <= ramp_cnt + 1;
		end
	end
	// An unpowered processor cannot signal a halt, so the pin falls with the rail.
	assign power_good_o = (ramp_cnt == RAMP);
	assign halt_o = halt_req_i && power_good_o;
endmodule

// ===== test_bus_timing_power_down_control.sv
`timescale 1ns/10ps
module test_bus_timing_power_down_control;
	logic clk = 1'b0;
	logic arst_n = 1'b0;
	logic [15:0] addr = 16'h0000;
	logic [15:0] wdata = 16'h0000;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic irq, dma, nmi, pmc_irq, wide, powerdown_refresh_in, bsrc, psrc, rreq, cbr_en, halt_req, pg, halt;
	logic cbusy;
	logic [15:0] rdata;
	logic rvalid, busy, poe_n, peoe_n, pmask, pull, amask, stop, cbr, refr, preset, shold, bclk;
	logic [7:0] power_mgmt_control;
	bus_power_pkg::bus_timing_t timing;
	int n_errors = 0;
	int compares = 0;
	int div = 0;
	int i, j, k;
	logic [15:0] w;
	time t_rise = 0;
	time t_prev = 0;
	int per[4] = '{128, 64, 192, 96};

	// Clock and slow source clocks that are sampled as data.
	always #2 clk = ~clk;
	always @(posedge clk) begin
		div <= div + 1;
		bsrc <= (div % 8) < 4;
		psrc <= (div % 12) < 6;
		rreq <= (div % 5) == 0;
	end
	// Bus clock period is taken from its last two rising edges.
	always @(posedge bclk) begin
		t_prev = t_rise;
		t_rise = $time;
	end

	bus_timing_power_down_control i_dut (
		.clk_i(clk), .arst_n_i(arst_n), .io_addr_i(addr), .io_wdata_i(wdata),
		.io_wr_i(wr), .io_rd_i(rd), .halt_i(halt), .irq_i(irq), .dma_req_i(dma),
		.nmi_i(nmi), .pmc_irq_i(pmc_irq), .processor_power_good_i(pg),
		.coproc_busy_i(cbusy), .wide_core_i(wide), .powerdown_refresh_in_i(powerdown_refresh_in),
		.bus_source_clock_i(bsrc), .processor_clock_i(psrc), .refresh_req_i(rreq),
		.cbr_refresh_en_i(cbr_en), .io_rdata_o(rdata), .io_rvalid_o(rvalid),
		.processor_busy_out_o(busy), .power_mgmt_control_o(power_mgmt_control),
		.processor_oe_n_o(poe_n), .periph_oe_n_o(peoe_n),
		.processor_input_mask_o(pmask), .processor_pullup_en_o(pull),
		.all_input_mask_o(amask), .internal_stop_o(stop), .cbr_refresh_o(cbr),
		.refresh_o(refr), .processor_reset_out_o(preset),
		.system_reset_hold_o(shold), .expansion_bus_clock_o(bclk), .bus_timing_o(timing)
	);
	cpu_rail_model i_rail (
		.clk_i(clk), .off_i(power_mgmt_control[5] | power_mgmt_control[7]), .halt_req_i(halt_req),
		.power_good_o(pg), .halt_o(halt)
	);

	task chk(input logic [17:0] got, input logic [17:0] exp);
		compares++;
		if (got !== exp) begin
			n_errors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task wr16(input logic [15:0] a, input logic [15:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	// A refused read shows neither a valid pulse nor data.
	task rd16(input logic [15:0] a, input logic [16:0] exp);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		chk({1'b0, rvalid, rdata}, {1'b0, exp});
	endtask
	task reset(input logic strap);
		@(posedge clk);
		arst_n <= 1'b0;
		wide <= strap;
		repeat (16) @(posedge clk);
		arst_n <= 1'b1;
		repeat (4) @(posedge clk);
	endtask
	// Expected timing worked out from the field codes.
	function automatic bus_power_pkg::bus_timing_t texp(input logic [15:0] v);
		bus_power_pkg::bus_timing_t t;
		t.sync_skip = v[11];
		t.req_delay_half = v[11] ? 2'h0 : v[9:8] == 2'h1 ? 2'h1 : v[9:8] == 2'h2 ? 2'h0 : 2'h2;
		t.ack_adjust_half = v[11] ? 3'h0 : v[7:6] == 2'h0 ? 3'h0 : v[7:6] == 2'h1 ? 3'h7 :
			v[7:6] == 2'h2 ? 3'h6 : 3'h1;
		t.wait_io_wide = v[5] ? 3'h2 : 3'h1;
		t.wait_mem_wide = v[4] ? 3'h2 : 3'h1;
		t.wait_io_narrow = {1'b0, v[3:2]} + 3'h2;
		t.wait_mem_narrow = {1'b0, v[1:0]} + 3'h2;
		return t;
	endfunction
	task end_sim();
		$display("compares %0d n_errors %0d", compares, n_errors);
		if (n_errors == 0 && compares > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	// Watchdog sized well above the fewer than two thousand cycles the tests need.
	initial begin
		repeat (40000) @(posedge clk);
		n_errors++;
		end_sim();
	end

	initial begin
		{irq, dma, nmi, pmc_irq, powerdown_refresh_in, cbr_en, halt_req, wide, cbusy} = 9'h000;
		reset(1'b0);
		rd16(16'h1872, {1'b1, 16'h00CA});
		chk(timing, texp(16'h00CA));
		// Each code of every bus timing field, with bit 12 always written as one.
		for (k = 0; k < 4; k++) begin
			w = {4'h1, k[1:0], k[1:0], k[1:0], k[0], k[1], k[1:0], k[1:0]};
			wr16(16'h1872, w);
			rd16(16'h1872, {1'b1, w & 16'hEFFF});
			chk(timing, texp(w));
			repeat (150) @(posedge clk);
			chk(18'(t_rise - t_prev), 18'(per[k]));
		end
		$display("test field codes done");
		wr16(16'h1872, 16'h00CA);
		wr16(16'h00F8, 16'h0000);
		#1 chk(busy, 1'b1);
		wr16(16'h00F0, 16'h5A5A);
		#1 chk(busy, 1'b0);
		// A rising busy pin sets the latch after the synchroniser; a 0F0 write clears it.
		cbusy <= 1'b1;
		repeat (4) @(posedge clk);
		#1 chk(busy, 1'b1);
		cbusy <= 1'b0;
		wr16(16'h00F0, 16'h0000);
		#1 chk(busy, 1'b0);
		wr16(16'h1872, 16'h80CA);
		wr16(16'h00FF, 16'h0000);
		#1 chk(busy, 1'b0);
		reset(1'b1);
		wr16(16'h00FC, 16'h0000);
		#1 chk(busy, 1'b0);
		reset(1'b0);
		$display("test busy done");
		// Processor power-down, woken by each source in turn.
		for (j = 0; j < 3; j++) begin
			wr16(16'h1872, 16'h00CA);
			wr16(16'h1872, 16'h40CA);
			halt_req <= 1'b1;
			for (i = 0; i < 50 && power_mgmt_control[5] !== 1'b1; i++) @(posedge clk);
			#1 chk({power_mgmt_control[5], poe_n, pmask, pull}, 4'b1110);
			rd16(16'h1872, 17'h00000);
			repeat (150) @(posedge clk);
			chk(18'(t_rise - t_prev), 18'd128);
			{nmi, dma, irq} <= 3'b001 << j;
			for (i = 0; i < 50 && power_mgmt_control[5] !== 1'b0; i++) @(posedge clk);
			#1 chk({power_mgmt_control[5], preset, poe_n}, 3'b011);
			@(posedge clk);
			{nmi, dma, irq} <= 3'b000;
			halt_req <= 1'b0;
			for (i = 0; i < 80 && poe_n !== 1'b0; i++) @(posedge clk);
			#1 chk({poe_n, preset}, 2'b01);
			rd16(16'h9072, {1'b1, 16'h0002});
			for (i = 0; i < 30 && preset !== 1'b0; i++) @(posedge clk);
			#1 chk(preset, 1'b0);
		end
		halt_req <= 1'b1;
		repeat (30) @(posedge clk);
		#1 chk(power_mgmt_control[5], 1'b0);
		halt_req <= 1'b0;
		$display("test processor power-down done");
		wr16(16'h1872, 16'h20CA);
		cbr_en <= 1'b1;
		halt_req <= 1'b1;
		for (i = 0; i < 50 && power_mgmt_control[7] !== 1'b1; i++) @(posedge clk);
		#1 chk({power_mgmt_control[7], peoe_n, amask, stop, cbr}, 5'h1F);
		for (k = 0; k < 3; k++) begin
			@(posedge clk);
			powerdown_refresh_in <= !k[0];
			repeat (4) @(posedge clk);
			#1 chk(refr, !k[0]);
		end
		halt_req <= 1'b0;
		pmc_irq <= 1'b1;
		for (i = 0; i < 50 && power_mgmt_control[7] !== 1'b0; i++) @(posedge clk);
		#1 chk({power_mgmt_control[7], preset, shold}, 3'b011);
		@(posedge clk);
		pmc_irq <= 1'b0;
		for (i = 0; i < 80 && shold !== 1'b0; i++) @(posedge clk);
		#1 chk({shold, pg}, 2'b01);
		for (i = 0; i < 30 && preset !== 1'b0; i++) @(posedge clk);
		rd16(16'h1872, {1'b1, 16'h20CA});
		wr16(16'h1872, 16'h00CA);
		rd16(16'h1872, {1'b1, 16'h00CA});
		$display("test full power-down done");
		end_sim();
	end
endmodule
